// file: lcx_host_port.sv
// Purpose: Extended instruction decoder and host port of a character LCD controller
// Assumes: Parallel strobe and I2C pins are asynchronous and are synchronised here
// Notes: Display-side outputs are configuration levels for the drive logic
//
// Overview of operation
// - Extended instruction set decodes while extended_set_select is 1, standard otherwise.
// - icon_mode_select 0: character mode at 1:18, voltage from character register.
// - icon_mode_select 1: icons only at 1:2, voltage from icon register.
// - Icon blink enable is independent of cursor and character blink.
// - Blink off: 160 icon bits come from glyph characters 0 to 3.
// - Blink on: even phase characters 0-3, odd phase characters 4-7.
// - Icon phases match cursor phases; underline and block show in even phase.
// - A glyph bit of one lights the icon, zero leaves it dark.
// - Pairing reversal resets to 0; 1 mirrors the split halves.
// - Column and row mirror reset to 0; 1 reverses that order.
// - Temperature coefficient select resets to 00; other codes pick alternatives.
// - Voltage instruction top bits 10 load character, 11 load icon register.
// - Zero value, display off or power down switch the generator off.
// - Byte mode moves one full byte per strobe with select lines.
// - Nibble mode moves high nibble then low nibble on upper lines.
// - Nibble mode status read also takes two transfers, upper first.
// - Nibble mode is chosen by instruction, not by a pin.
// - Addressed I2C slave pulls SDA low through the acknowledge clock of every byte it receives.
// - I2C transfers start with START and address; respond only when matched.
// - The device never holds SCL low while busy.
// - Function set over I2C forces bus_width_select to 1.
// - Busy reads 1 while executing; next instruction waits until 0.
`timescale 1ns/1ps
`default_nettype none
module lcx_host_port #(
  parameter int BLINK_CYC = lcx_pkg::BLINK_DIV,
  parameter logic [6:0] SLAVE_ADDR = lcx_pkg::I2C_ADDR
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic xfer_clk_pin,
  input wire logic register_select,
  input wire logic read_write_select,
  input wire logic [7:0] parallel_data_lines_in,
  output logic [7:0] parallel_data_lines_out,
  output logic parallel_data_lines_oe,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic power_down_pin,
  output logic bus_width_select,
  output logic extended_set_select,
  output logic icon_mode_select,
  output logic icon_blink_enable,
  output logic display_on,
  output logic cursor_underline_show,
  output logic cursor_block_show,
  output logic blink_odd_phase,
  output logic screen_pairing_reversed,
  output logic column_mirror,
  output logic row_mirror,
  output logic [1:0] temp_coef_select,
  output logic [5:0] char_mode_voltage_reg,
  output logic [5:0] icon_mode_voltage_reg,
  output logic vgen_enable,
  output logic [5:0] vgen_value,
  output logic busy_indicator,
  output logic [4:0] icon_row_index,
  output logic [4:0] icon_row_bits
);
  localparam int IN_W = 14;
  localparam logic [11:0] EXEC_LOAD = 12'(lcx_pkg::EXEC_CYC - 1);
  localparam logic [15:0] BLINK_HALF = 16'(BLINK_CYC / 2 - 1);

  typedef struct packed {
    logic [IN_W-1:0] in_m;
    logic [IN_W-1:0] in_s;
    logic [IN_W-1:0] in_p;
    logic dl, ext, im, ib, disp, cur, cblk, pair, colm, rowm;
    logic [1:0] tc;
    logic [5:0] va, vb;
    logic cg_sel;
    logic [6:0] ac;
    logic [7:0] last_data;
    logic [11:0] busy_cnt;
    logic busy;
    logic pend_v, pend_rs, pend_i2c;
    logic [7:0] pend_byte;
    logic nib_ph;
    logic [3:0] nib_hi;
    logic [7:0] db_o;
    logic db_oe;
    logic [15:0] blink_cnt;
    logic odd;
    logic [4:0] scan, scan_q;
    logic ul, blk, vg_en;
    logic [5:0] vg_val;
    lcx_pkg::lcx_i2c_t ist;
    logic byte_full;
    logic [2:0] bcnt;
    logic [7:0] sh;
    logic rd, ctrl_done, i2c_rs, sda_oe;
    logic we;
    logic [5:0] waddr;
    logic [4:0] wdata;
  } lcx_state_t;

  lcx_state_t s, nx;
  logic [5:0] raddr;
  logic fset_i2c;

  // Opcode match, shared by both instruction pages
  function automatic logic lcx_hit(input logic [7:0] b, input logic [7:0] m, input logic [7:0] v);
    return (b & m) == v;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Pin order in the synchroniser: e, rs, rw, db[7:0], scl, sda, pd
  always_comb begin
    logic e_n, e_p, rs_n, rw_n, scl_n, scl_p, sda_n, sda_p, pd_n;
    logic [7:0] db_n, rbyte, b;
    logic p_v, i_v, i_rs, scl_r, scl_f, start, stop;
    nx = s;
    fset_i2c = 1'b0;
    p_v = 1'b0;
    i_v = 1'b0;
    i_rs = 1'b0;
    b = s.pend_byte;
    nx.in_m = {xfer_clk_pin, register_select, read_write_select,
               parallel_data_lines_in, scl_in, sda_in, power_down_pin};
    nx.in_s = s.in_m;
    nx.in_p = s.in_s;
    {e_n, rs_n, rw_n, db_n, scl_n, sda_n, pd_n} = s.in_s;
    e_p = s.in_p[13];
    scl_p = s.in_p[2];
    sda_p = s.in_p[1];
    scl_r = scl_n & ~scl_p;
    scl_f = ~scl_n & scl_p;
    start = scl_n & scl_p & sda_p & ~sda_n;
    stop = scl_n & scl_p & ~sda_p & sda_n;
    rbyte = rs_n ? s.last_data : {s.busy, s.ac};

    // Parallel strobe: act on the falling edge of the strobe
    // falling edge capture
    if (e_p & ~e_n) begin
      nx.nib_ph = s.dl ? 1'b0 : ~s.nib_ph;
      if (!rw_n) begin
        if (s.dl) begin
          p_v = 1'b1;
          nx.pend_byte = db_n;
        end else if (!s.nib_ph) begin
          nx.nib_hi = db_n[7:4];
        end else begin
          p_v = 1'b1;
          nx.pend_byte = {s.nib_hi, db_n[7:4]};
        end
        nx.pend_rs = rs_n;
      end
    end
    nx.db_oe = e_n & rw_n;
    nx.db_o = (s.dl | ~s.nib_ph) ? rbyte : {rbyte[3:0], rbyte[3:0]};

    // I2C slave; SCL is input only, so the master is never stretched
    // no clock stretching
    unique case (s.ist)
      lcx_pkg::LCX_IDLE: ;
      lcx_pkg::LCX_ADDR, lcx_pkg::LCX_RX: begin
        if (scl_r) begin
          nx.sh = {s.sh[6:0], sda_n};
          nx.bcnt = s.bcnt + 3'd1;
          nx.byte_full = (s.bcnt == 3'd7);
        end
        // The SCL fall that closes START is no byte end; wait for eight bits
        if (scl_f && s.byte_full) begin
          nx.byte_full = 1'b0;
          if (s.ist == lcx_pkg::LCX_ADDR) begin
            if (s.sh[7:1] == SLAVE_ADDR) begin
              nx.ist = lcx_pkg::LCX_AACK;
              nx.rd = s.sh[0];
              nx.ctrl_done = 1'b0;
              nx.sda_oe = 1'b1;
            end else begin
              nx.ist = lcx_pkg::LCX_IDLE;
            end
          end else begin
            nx.ist = lcx_pkg::LCX_RACK;
            nx.sda_oe = 1'b1;
            if (!s.ctrl_done) begin
              nx.ctrl_done = 1'b1;
              nx.i2c_rs = s.sh[lcx_pkg::B_CO_RS];
            end else begin
              i_v = 1'b1;
              i_rs = s.i2c_rs;
            end
          end
        end
      end
      // ack held low through SCL high
      lcx_pkg::LCX_AACK, lcx_pkg::LCX_RACK: begin
        if (scl_f) begin
          nx.bcnt = 3'd0;
          if (s.rd) begin
            nx.ist = lcx_pkg::LCX_TX;
            nx.sh = {(s.i2c_rs ? s.last_data : {s.busy, s.ac})} << 1;
            nx.sda_oe = ~(s.i2c_rs ? s.last_data[7] : s.busy);
          end else begin
            nx.ist = lcx_pkg::LCX_RX;
            nx.sda_oe = 1'b0;
          end
        end
      end
      lcx_pkg::LCX_TX: begin
        if (scl_f) begin
          nx.bcnt = s.bcnt + 3'd1;
          if (s.bcnt == 3'd7) begin
            nx.ist = lcx_pkg::LCX_TACK;
            nx.sda_oe = 1'b0;
          end else begin
            nx.sda_oe = ~s.sh[7];
            nx.sh = s.sh << 1;
          end
        end
      end
      lcx_pkg::LCX_TACK: begin
        if (scl_r) begin
          nx.ist = sda_n ? lcx_pkg::LCX_IDLE : lcx_pkg::LCX_AACK;
          nx.sda_oe = 1'b0;
        end
      end
      default: nx.ist = lcx_pkg::LCX_IDLE;
    endcase
    if (start) begin
      nx.ist = lcx_pkg::LCX_ADDR;
      nx.bcnt = 3'd0;
      nx.byte_full = 1'b0;
      nx.sda_oe = 1'b0;
    end else if (stop) begin
      nx.ist = lcx_pkg::LCX_IDLE;
      nx.sda_oe = 1'b0;
    end
    if (i_v) begin
      nx.pend_byte = s.sh;
      nx.pend_rs = i_rs;
    end
    if (p_v | i_v) begin
      nx.pend_v = 1'b1;
      nx.pend_i2c = i_v & ~p_v;
    end

    // Execute the held instruction once the previous one is done
    // wait while busy
    nx.we = 1'b0;
    if (s.busy_cnt != 12'd0) begin
      nx.busy_cnt = s.busy_cnt - 12'd1;
    end else if (s.pend_v) begin
      nx.pend_v = p_v | i_v;
      nx.busy_cnt = EXEC_LOAD;
      if (s.pend_rs) begin
        nx.last_data = b;
        nx.ac = s.ac + 7'd1;
        nx.we = s.cg_sel;
        nx.waddr = s.ac[5:0];
        nx.wdata = b[4:0];
      end else if (lcx_hit(b, lcx_pkg::FSET_M, lcx_pkg::FSET_V)) begin
        fset_i2c = s.pend_i2c;
        nx.dl = s.pend_i2c | b[lcx_pkg::B_DL];
        nx.ext = b[lcx_pkg::B_EXT];
        nx.nib_ph = 1'b0;
      end else if (!s.ext) begin
        if (lcx_hit(b, lcx_pkg::DCTL_M, lcx_pkg::DCTL_V)) begin
          nx.disp = b[lcx_pkg::B_DISP];
          nx.cur = b[lcx_pkg::B_CUR];
          nx.cblk = b[lcx_pkg::B_CBLK];
        end else if (lcx_hit(b, lcx_pkg::DDAD_M, lcx_pkg::DDAD_V)) begin
          nx.ac = b[6:0];
          nx.cg_sel = 1'b0;
        end else if (lcx_hit(b, lcx_pkg::CGAD_M, lcx_pkg::CGAD_V)) begin
          nx.ac = {s.ac[6], b[5:0]};
          nx.cg_sel = 1'b1;
        end
      end else begin
        if (lcx_hit(b, lcx_pkg::ICON_M, lcx_pkg::ICON_V)) begin
          nx.im = b[lcx_pkg::B_IM];
          nx.ib = b[lcx_pkg::B_IB];
        end else if (lcx_hit(b, lcx_pkg::DCFG_M, lcx_pkg::DCFG_V)) begin
          nx.colm = b[lcx_pkg::B_COLM];
          nx.rowm = b[lcx_pkg::B_ROWM];
        end else if (lcx_hit(b, lcx_pkg::SCFG_M, lcx_pkg::SCFG_V)) begin
          nx.pair = b[lcx_pkg::B_PAIR];
        end else if (lcx_hit(b, lcx_pkg::TCS_M, lcx_pkg::TCS_V)) begin
          nx.tc = b[1:0];
        end else if (lcx_hit(b, lcx_pkg::VSET_M, lcx_pkg::VB_V)) begin
          nx.vb = b[5:0];
        end else if (lcx_hit(b, lcx_pkg::VSET_M, lcx_pkg::VA_V)) begin
          nx.va = b[5:0];
        end
      end
    end
    nx.busy = (nx.busy_cnt != 12'd0);

    // Blink phase shared by cursor and icons
    // common even/odd phase
    nx.blink_cnt = (s.blink_cnt == BLINK_HALF) ? 16'd0 : s.blink_cnt + 16'd1;
    if (s.blink_cnt == BLINK_HALF) begin
      nx.odd = ~s.odd;
    end
    nx.ul = s.cur & ~s.odd;
    nx.blk = s.cblk & ~s.odd;

    nx.vg_val = s.im ? s.vb : s.va;
    nx.vg_en = (nx.vg_val != 6'd0) & s.disp & ~pd_n;

    // Icon scan of 32 glyph rows, 5 icons per row
    nx.scan = s.scan + 5'd1;
    nx.scan_q = s.scan;
  end

  assign raddr = {s.ib & s.odd, s.scan};

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Power-on state is byte-wide, standard page, all mirrors off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.dl <= 1'b1;
    end else begin
      s <= nx;
    end
  end

  lcx_glyph_ram u_ram (
    .clk(clk),
    .we(s.we),
    .waddr(s.waddr),
    .wdata(s.wdata),
    .raddr(raddr),
    .rdata(icon_row_bits)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign parallel_data_lines_out = s.db_o;
  assign parallel_data_lines_oe = s.db_oe;
  assign sda_out = 1'b0;
  assign sda_oe = s.sda_oe;
  assign bus_width_select = s.dl;
  assign extended_set_select = s.ext;
  assign icon_mode_select = s.im;
  assign icon_blink_enable = s.ib;
  assign display_on = s.disp;
  assign cursor_underline_show = s.ul;
  assign cursor_block_show = s.blk;
  assign blink_odd_phase = s.odd;
  assign screen_pairing_reversed = s.pair;
  assign column_mirror = s.colm;
  assign row_mirror = s.rowm;
  assign temp_coef_select = s.tc;
  assign char_mode_voltage_reg = s.va;
  assign icon_mode_voltage_reg = s.vb;
  assign vgen_enable = s.vg_en;
  assign vgen_value = s.vg_val;
  assign busy_indicator = s.busy;
  assign icon_row_index = s.scan_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence e_fall_wr;
    s.in_p[13] && !s.in_s[13] && !s.in_s[11] && s.dl;
  endsequence
  sequence exec_start;
    !s.busy && s.busy_cnt == 12'd0 && s.pend_v;
  endsequence

  a_byte_capture: assert property (e_fall_wr |=> s.pend_v)
    else $error("byte write not captured on strobe fall");
  a_busy_run: assert property (exec_start |=> busy_indicator [*8])
    else $error("busy dropped too early");
  a_i2c_width: assert property (fset_i2c |=> bus_width_select)
    else $error("function set over I2C left nibble width");
  a_ack_low: assert property ((s.ist == lcx_pkg::LCX_RACK && s.in_s[2]) |-> sda_oe)
    else $error("SDA not held low during acknowledge");
  a_nack_release: assert property ((s.ist == lcx_pkg::LCX_TACK && s.in_s[2]
    && !s.in_p[2] && s.in_s[1]) |=> !sda_oe && s.ist == lcx_pkg::LCX_IDLE)
    else $error("SDA not released after NACK");
  a_gen_off: assert property (vgen_enable |-> vgen_value != 6'd0 && $past(display_on))
    else $error("generator on with zero value or display off");
  a_gen_select: assert property (1 |=> vgen_value ==
    ($past(icon_mode_select) ? $past(icon_mode_voltage_reg)
    : $past(char_mode_voltage_reg)))
    else $error("generator value from wrong register");
  a_even_cursor: assert property (cursor_underline_show |-> $past(!blink_odd_phase))
    else $error("underline shown in odd phase");
  a_icon_page: assert property (!icon_blink_enable |-> !raddr[5])
    else $error("odd glyph page used with blink off");
endmodule
`default_nettype wire

// file: lcx_pkg.sv
// Purpose: Shared constants for the LCD extended-command host port
// Assumes: 100 MHz block clock; instruction byte codes as listed below
// Notes: Opcodes are matched as (byte & mask) == value
package lcx_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int EXEC_NS = 40000;
  localparam int EXEC_CYC = (EXEC_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLINK_DIV = 52224;
  localparam logic [6:0] I2C_ADDR = 7'h3a; // Arbitrary slave address
  // ----------------------------------------
  // Opcode masks and values
  // ----------------------------------------
  localparam logic [7:0] FSET_M = 8'he0;
  localparam logic [7:0] FSET_V = 8'h20;
  localparam logic [7:0] DCTL_M = 8'hf8;
  localparam logic [7:0] DCTL_V = 8'h08;
  localparam logic [7:0] CGAD_M = 8'hc0;
  localparam logic [7:0] CGAD_V = 8'h40;
  localparam logic [7:0] DDAD_M = 8'h80;
  localparam logic [7:0] DDAD_V = 8'h80;
  localparam logic [7:0] ICON_M = 8'hf8;
  localparam logic [7:0] ICON_V = 8'h08;
  localparam logic [7:0] DCFG_M = 8'hfc;
  localparam logic [7:0] DCFG_V = 8'h04;
  localparam logic [7:0] SCFG_M = 8'hfe;
  localparam logic [7:0] SCFG_V = 8'h02;
  localparam logic [7:0] TCS_M = 8'hfc;
  localparam logic [7:0] TCS_V = 8'h10;
  localparam logic [7:0] VSET_M = 8'hc0;
  localparam logic [7:0] VA_V = 8'h80;
  localparam logic [7:0] VB_V = 8'hc0;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_DL = 4;
  localparam int B_EXT = 0;
  localparam int B_DISP = 2;
  localparam int B_CUR = 1;
  localparam int B_CBLK = 0;
  localparam int B_IM = 2;
  localparam int B_IB = 1;
  localparam int B_COLM = 1;
  localparam int B_ROWM = 0;
  localparam int B_PAIR = 0;
  localparam int B_CO_RS = 6;
  // ----------------------------------------
  // I2C slave states
  // ----------------------------------------
  typedef enum logic [2:0] {
    LCX_IDLE = 3'b000,
    LCX_ADDR = 3'b001,
    LCX_AACK = 3'b010,
    LCX_RX = 3'b011,
    LCX_RACK = 3'b100,
    LCX_TX = 3'b101,
    LCX_TACK = 3'b110
  } lcx_i2c_t;
endpackage

// file: lcx_glyph_ram.sv
// Purpose: 64 x 5 glyph memory with a registered read port
// Assumes: One write and one read port on the same clock
// Notes: Read data lag the read address by one cycle
`timescale 1ns/1ps
`default_nettype none
module lcx_glyph_ram #(
  parameter int AW = 6,
  parameter int DW = 5
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Write and registered read; no reset so it maps onto RAM
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// file: lcx_host_model.sv
// Purpose: Host microcontroller model driving the parallel strobe bus and I2C
// Assumes: Every pin change lands 1 ns after a rising clock edge
// Notes: Busy is polled as a level; the read path keeps RS and RW stable
`timescale 1ns/1ps
`default_nettype none
module lcx_host_model (
  input wire logic clk,
  input wire logic [7:0] pins,
  input wire logic sda,
  output logic e,
  output logic rs,
  output logic rw,
  output logic [7:0] d,
  output logic scl,
  output logic sda_low
);
  // ----------------------------------------
  // Idle levels and timing helper
  // ----------------------------------------
  initial begin
    e = 1'b0;
    rs = 1'b0;
    rw = 1'b0;
    d = 8'h00;
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------
  // Parallel bus
  // ----------------------------------------
  // qualifiers held past fall
  task automatic pxfer(input logic r, input logic w, input logic [7:0] v,
                       output logic [7:0] q);
    rs = r;
    rw = w;
    d = v;
    e = 1'b1;
    tick(6);
    q = pins;
    e = 1'b0;
    tick(6);
    // Released lines show junk, not the old value
    d = ~v;
  endtask
  task automatic wr(input logic nib, input logic r, input logic [7:0] b);
    logic [7:0] q;
    if (nib) begin
      pxfer(r, 1'b0, {b[7:4], 4'hf}, q);
      pxfer(r, 1'b0, {b[3:0], 4'hf}, q);
    end else begin
      pxfer(r, 1'b0, b, q);
    end
  endtask
  // ----------------------------------------
  // I2C master
  // ----------------------------------------
  // start before address
  task automatic i2c_start();
    sda_low = 1'b0;
    scl = 1'b1;
    tick(10);
    sda_low = 1'b1;
    tick(10);
    scl = 1'b0;
  endtask
  // Acknowledge is sampled early and late in the high phase
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    logic a1;
    for (int i = 7; i >= 0; i--) begin
      tick(3);
      sda_low = ~b[i];
      tick(7);
      scl = 1'b1;
      tick(10);
      scl = 1'b0;
    end
    tick(3);
    sda_low = 1'b0;
    tick(7);
    scl = 1'b1;
    tick(2);
    a1 = ~sda;
    tick(7);
    ack = a1 & ~sda;
    tick(1);
    scl = 1'b0;
  endtask
  task automatic i2c_stop();
    tick(3);
    sda_low = 1'b1;
    tick(7);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b0;
    tick(10);
  endtask
  // read the last byte, SDA left released so it is not acknowledged
  task automatic i2c_rd_last(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      tick(10);
      scl = 1'b1;
      tick(5);
      v[i] = sda;
      tick(5);
      scl = 1'b0;
    end
    tick(10);
    scl = 1'b1;
    tick(10);
    scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the extended-command host port
// Assumes: Blink divider shortened to 16 so phases flip within a few cycles
// Notes: Every instruction waits out busy, so the run is mostly idle time
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, x) begin checked++; if ((a) !== (x)) begin n_fail++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (x)); end end
module tb;
  logic clk, sys_rst, pd, e, rs, rw, scl, sda_low, sda, doe, sda_out, sda_oe;
  logic bw, ext, im, ib, disp, cul, cbl, odd, pair, colm, rowm, ven, busy, ack;
  logic [7:0] hd, pins, dout, g, h, q1, q2;
  logic [1:0] tc, pq;
  logic [5:0] va_r, vb_r, vval, va, vb;
  logic [4:0] ridx, rbits;
  int n_fail, checked, seed, cnt, n_odd;
  // ----------------------------------------
  // Wiring, clock and instances
  // ----------------------------------------
  // Low data lines carry pull-ups in nibble mode
  assign pins = doe ? dout : (bw ? hd : {hd[7:4], 4'hf});
  assign sda = ~(sda_low | sda_oe);
  always #5 clk = ~clk;
  lcx_host_model host (.clk(clk), .pins(pins), .sda(sda), .e(e), .rs(rs), .rw(rw),
    .d(hd), .scl(scl), .sda_low(sda_low));
  lcx_host_port #(.BLINK_CYC(16)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .xfer_clk_pin(e), .register_select(rs), .read_write_select(rw),
    .parallel_data_lines_in(pins), .parallel_data_lines_out(dout),
    .parallel_data_lines_oe(doe), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .power_down_pin(pd), .bus_width_select(bw),
    .extended_set_select(ext), .icon_mode_select(im), .icon_blink_enable(ib),
    .display_on(disp), .cursor_underline_show(cul), .cursor_block_show(cbl),
    .blink_odd_phase(odd), .screen_pairing_reversed(pair), .column_mirror(colm),
    .row_mirror(rowm), .temp_coef_select(tc), .char_mode_voltage_reg(va_r),
    .icon_mode_voltage_reg(vb_r), .vgen_enable(ven), .vgen_value(vval),
    .busy_indicator(busy), .icon_row_index(ridx), .icon_row_bits(rbits));
  // ----------------------------------------
  // Expectations and helpers
  // ----------------------------------------
  // Generator runs only with a nonzero selected value, display on, no power down
  function automatic logic [6:0] vexp(input logic m, input logic [5:0] a,
                                      input logic [5:0] b, input logic on);
    logic [5:0] v;
    v = m ? b : a;
    return {(v != 6'h00) & on & ~pd, v};
  endfunction
  task automatic idle();
    for (int k = 0; k < 5000 && busy !== 1'b0; k++) @(posedge clk);
    #1;
    `CHK(busy, 1'b0)
  endtask
  task automatic ins(input logic nib, input logic r, input logic [7:0] b);
    host.wr(nib, r, b);
    repeat (3) @(posedge clk);
    #1;
    `CHK(busy, 1'b1)
    idle();
  endtask
  task automatic summarize();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog well past the expected 80k cycles
  initial begin
    #950000;
    n_fail++;
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    pd = 1'b0;
    seed = 32'he341;
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK({bw, ext, im, ib, disp}, 5'h10)
    `CHK({pair, colm, rowm, tc}, 5'h00)
    // Icon row 0 of character 0, lit bits follow the stored ones
    g = 8'($random(seed));
    ins(1'b0, 1'b0, 8'h40);
    ins(1'b0, 1'b1, g);
    // Odd-page copy for row 0 of character 5, glyph address 40
    h = 8'($random(seed));
    ins(1'b0, 1'b0, 8'h68);
    ins(1'b0, 1'b1, h);
    for (int k = 0; k < 64 && ridx !== 5'h00; k++) @(negedge clk);
    `CHK(rbits, g[4:0])
    // Standard display control: display, cursor and character blink on
    ins(1'b0, 1'b0, 8'h0f);
    `CHK({disp, im}, 2'b10)
    cnt = 0;
    n_odd = 0;
    repeat (32) begin
      @(negedge clk);
      cnt += int'(cul);
      n_odd += int'(odd);
      `CHK(cul, cbl)
    end
    `CHK(cnt, 16)
    `CHK(n_odd, 16)
    ins(1'b0, 1'b0, 8'h31);
    `CHK({ext, bw}, 2'b11)
    for (int c = 0; c < 4; c++) begin
      ins(1'b0, 1'b0, 8'h10 | 8'(c));
      `CHK(tc, 2'(c))
    end
    va = 6'($random(seed));
    vb = 6'($random(seed));
    ins(1'b0, 1'b0, {2'b10, va});
    ins(1'b0, 1'b0, {2'b11, vb});
    `CHK({va_r, vb_r}, {va, vb})
    `CHK({ven, vval}, vexp(1'b0, va, vb, 1'b1))
    pq = 2'($random(seed));
    ins(1'b0, 1'b0, {6'h01, pq});
    ins(1'b0, 1'b0, {7'h01, ~pq[0]});
    `CHK({colm, rowm, pair}, {pq, ~pq[0]})
    ins(1'b0, 1'b0, 8'h0c);
    `CHK({im, ib, disp}, 3'b101)
    `CHK({ven, vval}, vexp(1'b1, va, vb, 1'b1))
    pd = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK(ven, 1'b0)
    pd = 1'b0;
    ins(1'b0, 1'b0, 8'h21);
    `CHK({bw, ext}, 2'b01)
    ins(1'b1, 1'b0, 8'h0a);
    `CHK({im, ib, ven, vval}, {2'b01, vexp(1'b0, va, vb, 1'b1)})
    // Blink on: row 8 scanned while odd reads character 5
    @(negedge clk);
    for (int k = 0; k < 64 && (ridx !== 5'h08 || n_odd != 1); k++) begin
      n_odd = int'(odd);
      @(negedge clk);
    end
    `CHK(rbits, h[4:0])
    ins(1'b1, 1'b0, 8'h80);
    `CHK({ven, va_r}, 7'h00)
    host.pxfer(1'b0, 1'b1, 8'hff, q1);
    host.pxfer(1'b0, 1'b1, 8'hff, q2);
    `CHK(q2[7:4], q1[3:0])
    `CHK(q1[7], 1'b0)
    // I2C: foreign address ignored, own address acknowledged per byte
    host.i2c_start();
    host.i2c_byte({lcx_pkg::I2C_ADDR ^ 7'h01, 1'b0}, ack);
    `CHK(ack, 1'b0)
    host.i2c_stop();
    host.i2c_start();
    host.i2c_byte({lcx_pkg::I2C_ADDR, 1'b0}, ack);
    `CHK(ack, 1'b1)
    host.i2c_byte(8'h00, ack);
    `CHK(ack, 1'b1)
    host.i2c_byte(8'h20, ack);
    `CHK(ack, 1'b1)
    host.i2c_stop();
    idle();
    `CHK({bw, ext, sda_out}, 3'b100)
    // Read back busy and address counter (after the write at glyph 40), then NACK
    host.i2c_start();
    host.i2c_byte({lcx_pkg::I2C_ADDR, 1'b1}, ack);
    `CHK(ack, 1'b1)
    host.i2c_rd_last(g);
    `CHK(g, 8'h29)
    `CHK(sda_oe, 1'b0)
    host.i2c_stop();
    summarize();
  end
endmodule
`default_nettype wire
